// ===== core/itb_bus_if.sv
`timescale 1ns/1ps
interface itb_bus_if;
   logic mSclOut;
   logic mSclOe;
   logic mSdaOut;
   logic mSdaOe;
   logic sSclOut;
   logic sSclOe;
   logic sSdaOut;
   logic sSdaOe;
   logic scl;
   logic sda;

   // Wired-AND with pull-ups: the line is low while any enabled driver pulls it low
   assign scl = !((mSclOe && !mSclOut) || (sSclOe && !sSclOut));
   assign sda = !((mSdaOe && !mSdaOut) || (sSdaOe && !sSdaOut));

   modport mst (output mSclOut, mSclOe, mSdaOut, mSdaOe, input scl, sda);
   modport slv (output sSclOut, sSclOe, sSdaOut, sSdaOe, input scl, sda);
endinterface

// ===== core/itb_defines.svh
`ifndef ITB_DEFINES_SVH
`define ITB_DEFINES_SVH

// System clock period
`define ITB_CLK_NS 100
// Half of one bus bit period driven by the master (400 kbit/s class)
`define ITB_T_HALF_NS 1250
`define ITB_HALF_CYC ((`ITB_T_HALF_NS + `ITB_CLK_NS - 1) / `ITB_CLK_NS)
// Spike width the input filter must reject
`define ITB_T_SPIKE_NS 50
`define ITB_FILT_CYC ((`ITB_T_SPIKE_NS + `ITB_CLK_NS - 1) / `ITB_CLK_NS + 1)
// Data set-up before the slave lets SCL go
`define ITB_T_SU_DAT_NS 250
`define ITB_SU_CYC ((`ITB_T_SU_DAT_NS + `ITB_CLK_NS - 1) / `ITB_CLK_NS)

// First-byte codes
`define ITB_TENBIT_PAT 5'h1E
`define ITB_GCALL_BYTE 8'h00
`define ITB_START_BYTE 8'h01
// Bit slot index of the acknowledge
`define ITB_ACK_SLOT 4'h8

`endif

// ===== core/itb_master.sv
`timescale 1ns/1ps
`include "itb_defines.svh"

module itb_master import itb_pkg::*; #(
   parameter int HALF_CYC = `ITB_HALF_CYC
) (
   input wire logic mclk, // System clock
   input wire logic rst_n, // Async reset
   itb_bus_if.mst bus, // Shared two-wire bus
   input wire logic cmdValid, // Command offered
   input wire itb_cmd_t cmdCode, // Bus action
   input wire logic [7:0] cmdData, // Byte to write
   input wire logic cmdAck, // Acknowledge a read byte
   output logic cmdReady, // Command taken when valid
   output logic cmdDone, // Pulse: command finished
   output logic [7:0] rdData, // Byte read
   output logic ackRcvd, // Slave acknowledged last write
   output logic busy // Bus owned
);

   localparam logic [4:0] HALF = 5'(HALF_CYC - 1);

   //////////////////////////////////////////////////////////////////////////
   // Bus line synchronisers
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic sclS;
   logic sdaS;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 2'h3;
         sync2_r <= 2'h3;
      end else begin
         sync1_r <= {bus.scl, bus.sda};
         sync2_r <= sync1_r;
      end
   end

   assign sclS = sync2_r[1];
   assign sdaS = sync2_r[0];

   //////////////////////////////////////////////////////////////////////////
   // Sequencer
   itb_mstate_t state_r, state_nxt;
   itb_cmd_t kind_r, kind_nxt;
   logic [4:0] cnt_r, cnt_nxt;
   logic [3:0] bit_r, bit_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic ackGive_r, ackGive_nxt;
   logic sclLow_r, sclLow_nxt;
   logic sdaLow_r, sdaLow_nxt;
   logic [7:0] rdData_r, rdData_nxt;
   logic ackRcvd_r, ackRcvd_nxt;
   logic done_r, done_nxt;
   logic want;

   assign cmdReady = (state_r == M_IDLE) || (state_r == M_HOLD);

   // Whether SDA is pulled low during the low phase (1 means low)
   always_comb begin
      case (kind_r)
         CMD_STOP: want = 1'b1;
         CMD_WRITE: want = (bit_r < `ITB_ACK_SLOT) ? !shift_r[7] : 1'b0;
         CMD_READ: want = (bit_r < `ITB_ACK_SLOT) ? 1'b0 : ackGive_r;
         default: want = 1'b0;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      cnt_nxt = cnt_r;
      bit_nxt = bit_r;
      shift_nxt = shift_r;
      ackGive_nxt = ackGive_r;
      sclLow_nxt = sclLow_r;
      sdaLow_nxt = sdaLow_r;
      rdData_nxt = rdData_r;
      ackRcvd_nxt = ackRcvd_r;
      done_nxt = 1'b0;
      case (state_r)
         M_IDLE: begin
            if (cmdValid) begin
               if (cmdCode == CMD_START) begin
                  sdaLow_nxt = 1'b1;
                  cnt_nxt = HALF;
                  state_nxt = M_STA;
               end else begin
                  done_nxt = 1'b1;
               end
            end
         end
         M_STA: begin
            if (cnt_r == 5'h0) begin
               sclLow_nxt = 1'b1;
               state_nxt = M_HOLD;
               done_nxt = 1'b1;
            end else begin
               cnt_nxt = cnt_r - 5'h1;
            end
         end
         M_HOLD: begin
            if (cmdValid) begin
               if (cmdCode == CMD_START) begin
                  done_nxt = 1'b1;
               end else begin
                  // Any address width may follow each start
                  kind_nxt = cmdCode;
                  bit_nxt = 4'h0;
                  shift_nxt = cmdData;
                  ackGive_nxt = cmdAck;
                  cnt_nxt = HALF;
                  state_nxt = M_SDA;
               end
            end
         end
         M_SDA: begin
            sdaLow_nxt = want;
            if (cnt_r == 5'h0) begin
               sclLow_nxt = 1'b0;
               state_nxt = M_RISE;
            end else begin
               cnt_nxt = cnt_r - 5'h1;
            end
         end
         M_RISE: begin
            // A slave holding SCL low makes us wait here
            if (sclS) begin
               cnt_nxt = HALF;
               state_nxt = M_HIGH;
            end
         end
         M_HIGH: begin
            if (cnt_r != 5'h0) begin
               cnt_nxt = cnt_r - 5'h1;
            end else if (kind_r == CMD_RSTART) begin
               sdaLow_nxt = 1'b1;
               cnt_nxt = HALF;
               state_nxt = M_STA;
            end else if (kind_r == CMD_STOP) begin
               sdaLow_nxt = 1'b0;
               state_nxt = M_IDLE;
               done_nxt = 1'b1;
            end else begin
               sclLow_nxt = 1'b1;
               if (bit_r == `ITB_ACK_SLOT) begin
                  ackRcvd_nxt = !sdaS;
                  rdData_nxt = shift_r;
                  state_nxt = M_HOLD;
                  done_nxt = 1'b1;
               end else begin
                  shift_nxt = {shift_r[6:0], sdaS};
                  bit_nxt = bit_r + 4'h1;
                  cnt_nxt = HALF;
                  state_nxt = M_SDA;
               end
            end
         end
         default: begin
            state_nxt = M_IDLE;
            sclLow_nxt = 1'b0;
            sdaLow_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= M_IDLE;
         kind_r <= CMD_START;
         cnt_r <= 5'h0;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         ackGive_r <= 1'b0;
         sclLow_r <= 1'b0;
         sdaLow_r <= 1'b0;
         rdData_r <= 8'h00;
         ackRcvd_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         cnt_r <= cnt_nxt;
         bit_r <= bit_nxt;
         shift_r <= shift_nxt;
         ackGive_r <= ackGive_nxt;
         sclLow_r <= sclLow_nxt;
         sdaLow_r <= sdaLow_nxt;
         rdData_r <= rdData_nxt;
         ackRcvd_r <= ackRcvd_nxt;
         done_r <= done_nxt;
      end
   end

   assign bus.mSclOut = 1'b0;
   assign bus.mSclOe = sclLow_r;
   assign bus.mSdaOut = 1'b0;
   assign bus.mSdaOe = sdaLow_r;
   assign cmdDone = done_r;
   assign rdData = rdData_r;
   assign ackRcvd = ackRcvd_r;
   assign busy = (state_r != M_IDLE);

endmodule // itb_master

// ===== core/itb_pkg.sv
package itb_pkg;

   typedef enum logic [2:0] {
      CMD_START = 3'h0,
      CMD_RSTART = 3'h1,
      CMD_STOP = 3'h2,
      CMD_WRITE = 3'h3,
      CMD_READ = 3'h4
   } itb_cmd_t;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_FIRST = 6'h02,
      S_SECOND = 6'h04,
      S_WRITE = 6'h08,
      S_READ = 6'h10,
      S_IGNORE = 6'h20
   } itb_sstate_t;

   typedef enum logic [5:0] {
      M_IDLE = 6'h01,
      M_HOLD = 6'h02,
      M_STA = 6'h04,
      M_SDA = 6'h08,
      M_RISE = 6'h10,
      M_HIGH = 6'h20
   } itb_mstate_t;

endpackage

// ===== core/itb_slave.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "itb_defines.svh"

module itb_slave import itb_pkg::*; (
   input wire logic mclk, // System clock
   input wire logic rst_n, // Async reset
   itb_bus_if.slv bus, // Shared two-wire bus
   input wire logic [9:0] ownAddr, // Ten-bit slave address
   input wire logic gcallEn, // Answer general call
   output logic [7:0] rxData, // Received data byte
   output logic rxValid, // Pulse: rxData new
   output logic rxIsGcall, // rxData came after general call
   input wire logic [7:0] txData, // Byte to send to master
   input wire logic txValid, // txData available
   output logic txReady, // Pulse: txData taken
   output logic selected, // Addressed by full ten-bit address
   output logic busActive, // Between START and STOP, addressed or not
   output logic firstAddressAck, // Pulse: first address ack given
   output logic secondAddressAck, // Pulse: second address ack given
   output logic readTurnaroundAck // Pulse: read turnaround ack given
);

   localparam logic [1:0] FILT_M1 = 2'(`ITB_FILT_CYC - 1);
   localparam logic [1:0] SU_CYC = 2'(`ITB_SU_CYC);

   //////////////////////////////////////////////////////////////////////////
   // Input synchronisers and spike filters
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] filt;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 2'h3;
         sync2_r <= 2'h3;
      end else begin
         sync1_r <= {bus.scl, bus.sda};
         sync2_r <= sync1_r;
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_filt
      logic [1:0] fc_r;
      logic [1:0] fc_nxt;
      logic fl_r;
      logic fl_nxt;

      // A new level must hold longer than a spike before it is believed
      always_comb begin
         fc_nxt = 2'h0;
         fl_nxt = fl_r;
         if (sync2_r[i] != fl_r) begin
            if (fc_r == FILT_M1) begin
               fl_nxt = sync2_r[i];
            end else begin
               fc_nxt = fc_r + 2'h1;
            end
         end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            fc_r <= 2'h0;
            fl_r <= 1'b1;
         end else begin
            fc_r <= fc_nxt;
            fl_r <= fl_nxt;
         end
      end

      assign filt[i] = fl_r;
   end

   //////////////////////////////////////////////////////////////////////////
   // Bus events
   logic sclF;
   logic sdaF;
   logic sclD_r;
   logic sdaD_r;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;

   assign sclF = filt[1];
   assign sdaF = filt[0];
   assign sclRise = sclF && !sclD_r;
   assign sclFall = !sclF && sclD_r;
   assign startEv = sclF && sclD_r && sdaD_r && !sdaF;
   assign stopEv = sclF && sclD_r && !sdaD_r && sdaF;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
      end else begin
         sclD_r <= sclF;
         sdaD_r <= sdaF;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Protocol engine
   itb_sstate_t state_r, state_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] rxShift_r, rxShift_nxt;
   logic [7:0] txShift_r, txShift_nxt;
   logic ackDrive_r, ackDrive_nxt;
   logic needTx_r, needTx_nxt;
   logic [1:0] suCnt_r, suCnt_nxt;
   logic prevSel_r, prevSel_nxt;
   logic gcall_r, gcall_nxt;
   logic [7:0] rxData_r, rxData_nxt;
   logic rxValid_r, rxValid_nxt;
   logic rxIsGcall_r, rxIsGcall_nxt;
   logic ack1_r, ack1_nxt;
   logic ack2_r, ack2_nxt;
   logic ack3_r, ack3_nxt;

   assign txReady = needTx_r && txValid && (state_r == S_READ);

   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      rxShift_nxt = rxShift_r;
      txShift_nxt = txShift_r;
      ackDrive_nxt = ackDrive_r;
      needTx_nxt = needTx_r;
      suCnt_nxt = (suCnt_r != 2'h0) ? suCnt_r - 2'h1 : 2'h0;
      prevSel_nxt = prevSel_r;
      gcall_nxt = gcall_r;
      rxData_nxt = rxData_r;
      rxValid_nxt = 1'b0;
      rxIsGcall_nxt = rxIsGcall_r;
      ack1_nxt = 1'b0;
      ack2_nxt = 1'b0;
      ack3_nxt = 1'b0;
      if (startEv) begin
         // Selection memory is kept so a read can follow
         state_nxt = S_FIRST;
         // SCL fall closing the START wraps this to zero, not bit one
         bitCnt_nxt = 4'hF;
         ackDrive_nxt = 1'b0;
         needTx_nxt = 1'b0;
         suCnt_nxt = 2'h0;
         gcall_nxt = 1'b0;
      end else if (stopEv) begin
         state_nxt = S_IDLE;
         prevSel_nxt = 1'b0;
         bitCnt_nxt = 4'h0;
         ackDrive_nxt = 1'b0;
         needTx_nxt = 1'b0;
         suCnt_nxt = 2'h0;
      end else begin
         if (txReady) begin
            txShift_nxt = txData;
            needTx_nxt = 1'b0;
            suCnt_nxt = SU_CYC;
         end
         if (sclRise && bitCnt_r < `ITB_ACK_SLOT) begin
            rxShift_nxt = {rxShift_r[6:0], sdaF};
         end
         // Master not acknowledging ends the read
         if (sclRise && bitCnt_r == `ITB_ACK_SLOT && state_r == S_READ && sdaF) begin
            state_nxt = S_IGNORE;
         end
         if (sclFall) begin
            if (bitCnt_r == `ITB_ACK_SLOT) begin
               bitCnt_nxt = 4'h0;
               ackDrive_nxt = 1'b0;
               if (state_r == S_READ) begin
                  needTx_nxt = 1'b1;
               end
            end else begin
               bitCnt_nxt = bitCnt_r + 4'h1;
               if (state_r == S_READ) begin
                  txShift_nxt = {txShift_r[6:0], 1'b1};
               end
               if (bitCnt_r == 4'h7) begin
                  case (state_r)
                     S_FIRST: begin
                        if (rxShift_r == `ITB_GCALL_BYTE) begin
                           if (gcallEn) begin
                              state_nxt = S_WRITE;
                              ackDrive_nxt = 1'b1;
                              gcall_nxt = 1'b1;
                           end else begin
                              state_nxt = S_IGNORE;
                           end
                        end else if (rxShift_r == `ITB_START_BYTE) begin
                           state_nxt = S_IGNORE;
                        end else if (rxShift_r[7:3] == `ITB_TENBIT_PAT &&
                                     rxShift_r[2:1] == ownAddr[9:8]) begin
                           if (!rxShift_r[0]) begin
                              state_nxt = S_SECOND;
                              ackDrive_nxt = 1'b1;
                              ack1_nxt = 1'b1;
                           end else if (prevSel_r) begin
                              state_nxt = S_READ;
                              ackDrive_nxt = 1'b1;
                              ack3_nxt = 1'b1;
                           end else begin
                              state_nxt = S_IGNORE;
                           end
                        end else begin
                           // Seven-bit, reserved or other ten-bit address
                           state_nxt = S_IGNORE;
                           prevSel_nxt = 1'b0;
                        end
                     end
                     S_SECOND: begin
                        if (rxShift_r == ownAddr[7:0]) begin
                           state_nxt = S_WRITE;
                           ackDrive_nxt = 1'b1;
                           ack2_nxt = 1'b1;
                           prevSel_nxt = 1'b1;
                        end else begin
                           state_nxt = S_IGNORE;
                           prevSel_nxt = 1'b0;
                        end
                     end
                     S_WRITE: begin
                        ackDrive_nxt = 1'b1;
                        rxData_nxt = rxShift_r;
                        rxValid_nxt = 1'b1;
                        rxIsGcall_nxt = gcall_r;
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         bitCnt_r <= 4'h0;
         rxShift_r <= 8'h00;
         txShift_r <= 8'hFF;
         ackDrive_r <= 1'b0;
         needTx_r <= 1'b0;
         suCnt_r <= 2'h0;
         prevSel_r <= 1'b0;
         gcall_r <= 1'b0;
         rxData_r <= 8'h00;
         rxValid_r <= 1'b0;
         rxIsGcall_r <= 1'b0;
         ack1_r <= 1'b0;
         ack2_r <= 1'b0;
         ack3_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         rxShift_r <= rxShift_nxt;
         txShift_r <= txShift_nxt;
         ackDrive_r <= ackDrive_nxt;
         needTx_r <= needTx_nxt;
         suCnt_r <= suCnt_nxt;
         prevSel_r <= prevSel_nxt;
         gcall_r <= gcall_nxt;
         rxData_r <= rxData_nxt;
         rxValid_r <= rxValid_nxt;
         rxIsGcall_r <= rxIsGcall_nxt;
         ack1_r <= ack1_nxt;
         ack2_r <= ack2_nxt;
         ack3_r <= ack3_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Pin drive: open drain, enable means pull low
   logic txDrive;

   assign txDrive = (state_r == S_READ) && (bitCnt_r < `ITB_ACK_SLOT) && !needTx_r &&
                    !txShift_r[7];
   assign bus.sSdaOut = 1'b0;
   assign bus.sSdaOe = ackDrive_r || txDrive;
   assign bus.sSclOut = 1'b0;
   // Hold SCL low until a byte is loaded and settled on SDA
   assign bus.sSclOe = needTx_r || (suCnt_r != 2'h0);

   assign rxData = rxData_r;
   assign rxValid = rxValid_r;
   assign rxIsGcall = rxIsGcall_r;
   assign selected = prevSel_r;
   assign busActive = (state_r != S_IDLE);
   assign firstAddressAck = ack1_r;
   assign secondAddressAck = ack2_r;
   assign readTurnaroundAck = ack3_r;

endmodule // itb_slave

// ===== sim/i2c_ten_bit_addressing_bench.sv
`timescale 1ns/1ps
module i2c_ten_bit_addressing_bench import itb_pkg::*;;
   logic mclk = 0, rst_n = 0, cmdValid = 0, cmdAck = 0, gcallEn = 1, txValid = 1;
   itb_cmd_t cmdCode = CMD_STOP;
   logic [7:0] cmdData = 8'h00, txData = 8'h00, rxData, rdData, d;
   logic [9:0] ownAddr = 10'h000;
   logic cmdReady, cmdDone, ackRcvd, busy, rxValid, rxIsGcall, txReady, selected, busActive;
   logic firstAddressAck, secondAddressAck, readTurnaroundAck;
   logic [8:0] rxQ[$];
   logic [7:0] rdQ[$];
   int errors = 0, samples_checked = 0;
   wire logic [7:0] hi = {5'b11110, ownAddr[9:8], 1'b0};
   itb_bus_if bus();
   always #50 mclk = ~mclk;
   itb_master #(.HALF_CYC(8)) u_itb_master (.mclk, .rst_n, .bus, .cmdValid, .cmdCode,
      .cmdData, .cmdAck, .cmdReady, .cmdDone, .rdData, .ackRcvd, .busy);
   itb_slave u_itb_slave (.mclk, .rst_n, .bus, .ownAddr, .gcallEn, .rxData, .rxValid,
      .rxIsGcall, .txData, .txValid, .txReady, .selected, .busActive, .firstAddressAck,
      .secondAddressAck, .readTurnaroundAck);
   itb_chk u_itb_chk (.mclk, .rst_n, .mSclOut(bus.mSclOut), .mSclOe(bus.mSclOe),
      .mSdaOut(bus.mSdaOut), .mSdaOe(bus.mSdaOe), .sSclOut(bus.sSclOut),
      .sSclOe(bus.sSclOe), .sSdaOut(bus.sSdaOut), .sSdaOe(bus.sSdaOe), .scl(bus.scl),
      .sda(bus.sda));
   //////////////////////////////
   task automatic conclude();
      $display("errors=%0d checks=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic cmd(input itb_cmd_t c, input logic [7:0] b, input logic a);
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      cmdValid = 1;
      cmdCode = c;
      cmdData = b;
      cmdAck = a;
      while (cmdReady !== 1'b1) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      #1;
      cmdValid = 0;
      while (cmdDone !== 1'b1 && n < 4000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 4000) begin
         errors++;
         $display("CHECK FAILED %0t command never finished", $time);
         conclude();
      end
   endtask
   task automatic wr(input logic [7:0] b, input logic ack);
      cmd(CMD_WRITE, b, 1'b0);
      chk(ackRcvd === ack, "acknowledge");
   endtask
   // Data byte to the slave, noted for the monitor
   task automatic dat(input logic g);
      d = 8'($urandom);
      rxQ.push_back({g, d});
      wr(d, 1'b1);
   endtask
   task automatic sel(input itb_cmd_t s, input logic [7:0] lo, input logic a2);
      cmd(s, 8'h00, 1'b0);
      wr(hi, 1'b1);
      wr(lo, a2);
   endtask
   task automatic stp(input logic expSel);
      cmd(CMD_STOP, 8'h00, 1'b0);
      repeat (10) @(posedge mclk);
      #1;
      chk(selected === expSel, "selected after stop");
   endtask
   task automatic rd(input logic a);
      cmd(CMD_READ, 8'h00, a);
      chk(rdData === rdQ.pop_front(), "read data");
   endtask
   //////////////////////////////
   // Slave fetches at txReady; next byte offered right after
   always @(posedge mclk) begin
      if (txReady === 1'b1) begin
         rdQ.push_back(txData);
         #1 txData = 8'($urandom);
      end
   end
   always @(posedge mclk) begin
      if (rxValid === 1'b1)
         chk({rxIsGcall, rxData} === rxQ.pop_front(), "received byte");
   end
   initial begin
      #6_000_000;
      errors++;
      conclude();
   end
   initial begin
      void'($urandom(32'h0000_efe0));
      ownAddr = 10'($urandom);
      txData = 8'($urandom);
      repeat (16) @(posedge mclk);
      #1 rst_n = 1;
      repeat (10) @(posedge mclk);
      sel(CMD_START, ownAddr[7:0], 1'b1);
      chk(selected === 1'b1, "selected");
      dat(1'b0);
      dat(1'b0);
      cmd(CMD_RSTART, 8'h00, 1'b0);
      wr(hi | 8'h01, 1'b1);
      rd(1'b1);
      rd(1'b0);
      cmd(CMD_RSTART, 8'h00, 1'b0);
      wr(hi ^ 8'h07, 1'b0);
      stp(1'b0);
      // Wrong low byte, then an unselected read
      sel(CMD_START, ownAddr[7:0] ^ 8'h01, 1'b0);
      cmd(CMD_RSTART, 8'h00, 1'b0);
      wr(hi | 8'h01, 1'b0);
      stp(1'b0);
      foreach (rdQ[i]) chk(1'b0, "unexpected fetch");
      cmd(CMD_START, 8'h00, 1'b0);
      wr(hi | 8'h08, 1'b0);
      stp(1'b0);
      // Start byte, then ten-bit addressing after a repeated start
      cmd(CMD_START, 8'h00, 1'b0);
      wr(8'h01, 1'b0);
      sel(CMD_RSTART, ownAddr[7:0], 1'b1);
      dat(1'b0);
      stp(1'b0);
      // Seven-bit address then ten-bit in one occupation
      cmd(CMD_START, 8'h00, 1'b0);
      wr({2'b01, 5'($urandom), 1'b0}, 1'b0);
      sel(CMD_RSTART, ownAddr[7:0], 1'b1);
      dat(1'b0);
      stp(1'b0);
      // General call with two data bytes, then refused once gcallEn is cleared
      cmd(CMD_START, 8'h00, 1'b0);
      wr(8'h00, 1'b1);
      dat(1'b1);
      dat(1'b1);
      stp(1'b0);
      gcallEn = 0;
      cmd(CMD_START, 8'h00, 1'b0);
      wr(8'h00, 1'b0);
      stp(1'b0);
      chk(rxQ.size() == 0, "missing received bytes");
      conclude();
   end
endmodule // i2c_ten_bit_addressing_bench

// ===== sim/itb_chk.sv
`timescale 1ns/1ps
module itb_chk (
   input wire logic mclk, // Clock
   input wire logic rst_n, // Reset
   input wire logic mSclOut, // Master SCL level
   input wire logic mSclOe, // Master SCL pull
   input wire logic mSdaOut, // Master SDA level
   input wire logic mSdaOe, // Master SDA pull
   input wire logic sSclOut, // Slave SCL level
   input wire logic sSclOe, // Slave SCL pull
   input wire logic sSdaOut, // Slave SDA level
   input wire logic sSdaOe, // Slave SDA pull
   input wire logic scl, // Resolved clock line
   input wire logic sda // Resolved data line
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   //////////////////////////////
   property p_odrain; !(mSclOut || mSdaOut || sSclOut || sSdaOut); endproperty
   a_odrain: assert property (p_odrain) else $error("line driven high");
   // A slave change while SCL high would fake a START or STOP
   property p_sdachg; $changed(sSdaOe) |-> !scl; endproperty
   a_sdachg: assert property (p_sdachg) else $error("slave SDA moved, SCL high");
   property p_strst; $rose(sSclOe) |-> mSclOe && !$past(scl); endproperty
   a_strst: assert property (p_strst) else $error("stretch not in low phase");
   property p_strend; $rose(sSclOe) |-> ##[1:12] !sSclOe; endproperty
   a_strend: assert property (p_strend) else $error("stretch too long");
   property p_setup; $fell(sSclOe) |-> $stable(sSdaOe) && sSdaOe == $past(sSdaOe, 2); endproperty
   a_setup: assert property (p_setup) else $error("data set-up short");
   property p_high; $rose(scl) |-> scl [*8]; endproperty
   a_high: assert property (p_high) else $error("SCL high too short");
   property p_low; $fell(scl) |-> !scl [*6]; endproperty
   a_low: assert property (p_low) else $error("SCL low too short");
   property p_start; $fell(sda) && scl |-> !sSdaOe && !sSclOe; endproperty
   a_start: assert property (p_start) else $error("slave driving at START");
endmodule // itb_chk
